// ==== src/tlc_pkg.sv ====
`default_nettype none
package tlc_pkg;
  // Clock
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned BIT_NS = 100;
  // Timing in printed units and derived cycle counts
  localparam int unsigned LP_WIDTH_NS = 100;
  localparam int unsigned LP_WIDTH_CYC = LP_WIDTH_NS / CLK_NS;
  localparam int unsigned LP_PERIOD_MS = 16;
  localparam int unsigned LP_PERIOD_CYC = LP_PERIOD_MS * (CLK_HZ / 1000);
  localparam int unsigned JAB_MS = 26;
  localparam int unsigned JAB_CYC = JAB_MS * (CLK_HZ / 1000);
  localparam int unsigned UNJAB_MS = 750;
  localparam int unsigned UNJAB_CYC = UNJAB_MS * (CLK_HZ / 1000);
  localparam int unsigned LINK_LOSS_MS = 100;
  localparam int unsigned LINK_LOSS_CYC = LINK_LOSS_MS * (CLK_HZ / 1000);
  localparam int unsigned HB_DELAY_NS = 1000;
  localparam int unsigned HB_DELAY_CYC = HB_DELAY_NS / CLK_NS;
  localparam int unsigned SQE_BITS = 10;
  localparam int unsigned SQE_CYC = SQE_BITS * BIT_NS / CLK_NS;
  localparam int unsigned COL_BITS = 7;
  localparam int unsigned COL_CYC = (COL_BITS * BIT_NS + CLK_NS - 1) / CLK_NS;
  // Polarity thresholds
  localparam logic [2:0] POL_LP_COUNT = 3'h7;
  localparam logic [2:0] POL_EOP_COUNT = 3'h3;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam logic [7:0] INT_STAT_OFF = 8'h08;
  localparam logic [7:0] INT_MASK_OFF = 8'h0C;
  localparam logic [7:0] LOOPBACK_BYPASS_ERR_OFF = 8'h18;
  localparam logic [7:0] TENMEG_CONFIG_OFF = 8'h1C;
  // Field positions
  localparam int unsigned CTRL_FDX_BIT = 0;
  localparam int unsigned CTRL_HB_BIT = 1;
  localparam int unsigned CTRL_LIDIS_BIT = 2;
  localparam int unsigned LPBK_BIT = 11;
  localparam int unsigned CFG_LSS_BIT = 2;
  localparam int unsigned CFG_CABLE_BIT = 3;
  // Reset values
  localparam logic [2:0] CTRL_RST = 3'h2;
  localparam logic [3:0] INT_MASK_RST = 4'h0;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // MII transmit and line-side inputs, raw and after synchronisation
  typedef struct packed {
    logic tx_en;
    logic txd;
    logic rx_act;
    logic rxd;
    logic lp;
    logic lp_inv;
    logic eop;
    logic eop_inv;
  } tlc_line_in_type;
endpackage : tlc_pkg
`default_nettype wire

// ==== src/tlc_link_ctrl.sv ====
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`default_nettype none
module tlc_link_ctrl #(
  parameter int unsigned LP_PERIOD = tlc_pkg::LP_PERIOD_CYC,
  parameter int unsigned JAB_LIMIT = tlc_pkg::JAB_CYC,
  parameter int unsigned UNJAB_LIMIT = tlc_pkg::UNJAB_CYC,
  parameter int unsigned LINK_LOSS = tlc_pkg::LINK_LOSS_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // MII side
  input wire logic mii_tx_en,
  input wire logic mii_txd,
  output logic mii_col,
  output logic mii_rx_dv,
  output logic mii_rxd,
  // Receive front end
  input wire logic line_rx_act,
  input wire logic line_rxd,
  input wire logic line_lp,
  input wire logic line_lp_inv,
  input wire logic line_eop,
  input wire logic line_eop_inv,
  output logic low_squelch_select,
  output logic twisted_pair_rx_en,
  // Transmit pairs
  output logic unshielded_tx_pair_o,
  output logic unshielded_tx_pair_oe,
  output logic shielded_tx_pair_o,
  output logic shielded_tx_pair_oe,
  // Indicators and interrupt
  output logic led_tx,
  output logic led_rx,
  output logic link_indicator,
  output logic polarity_indicator,
  output logic led_col,
  output logic irq
);

  // Input synchroniser and edge history
  tlc_pkg::tlc_line_in_type raw_in;
  tlc_pkg::tlc_line_in_type sync1_reg;
  tlc_pkg::tlc_line_in_type s_reg;
  tlc_pkg::tlc_line_in_type prev_reg;

  assign raw_in = '{mii_tx_en, mii_txd, line_rx_act, line_rxd,
                    line_lp, line_lp_inv, line_eop, line_eop_inv};

  always_ff @(posedge aclk) begin
    sync1_reg <= raw_in;
    s_reg <= sync1_reg;
    prev_reg <= s_reg;
  end

  // Software registers
  logic [2:0] ctrl_reg;
  logic [3:0] int_mask_reg;
  logic [3:0] int_stat_reg;
  logic lpbk_reg;
  logic [1:0] cfg_reg;

  // Core state
  logic link_ok_reg;
  logic bad_pol_reg;
  logic jabbed_reg;
  logic [31:0] loss_cnt_reg;
  logic [31:0] lp_cnt_reg;
  logic [31:0] jab_cnt_reg;
  logic [31:0] unjab_cnt_reg;
  logic [7:0] hb_cnt_reg;
  logic [7:0] col_cnt_reg;
  logic [2:0] lpi_cnt_reg;
  logic [2:0] eopi_cnt_reg;

  // Mode decode
  wire fdx = ctrl_reg[tlc_pkg::CTRL_FDX_BIT];
  wire hb_en = ctrl_reg[tlc_pkg::CTRL_HB_BIT];
  wire li_dis = ctrl_reg[tlc_pkg::CTRL_LIDIS_BIT];
  wire use_stp = cfg_reg[1];
  wire link_eff = link_ok_reg | li_dis | lpbk_reg;

  // Edge detection on synchronised line events
  wire lp_edge = s_reg.lp & ~prev_reg.lp;
  wire lpi_edge = s_reg.lp_inv & ~prev_reg.lp_inv;
  wire eop_edge = s_reg.eop & ~prev_reg.eop;
  wire eopi_edge = s_reg.eop_inv & ~prev_reg.eop_inv;
  wire tx_end = ~s_reg.tx_en & prev_reg.tx_en;

  // Link integrity: any pulse renews, silence drops link
  wire any_lp = lp_edge | lpi_edge;
  wire loss_hit = (loss_cnt_reg >= LINK_LOSS - 1);
  wire [31:0] loss_cnt_next = (any_lp | s_reg.rx_act | loss_hit) ? 32'h0
                              : loss_cnt_reg + 32'h1;
  wire link_ok_next = any_lp | (link_ok_reg & ~loss_hit);

  // Polarity detection
  wire [2:0] lpi_cnt_next = lp_edge ? 3'h0
                          : (lpi_edge & ~&lpi_cnt_reg) ? lpi_cnt_reg + 3'h1
                          : lpi_cnt_reg;
  wire [2:0] eopi_cnt_next = eop_edge ? 3'h0
                           : (eopi_edge & (eopi_cnt_reg != tlc_pkg::POL_EOP_COUNT))
                           ? eopi_cnt_reg + 3'h1 : eopi_cnt_reg;
  wire bad_pol_next = bad_pol_reg
                    | (lpi_cnt_next == tlc_pkg::POL_LP_COUNT)
                    | (eopi_cnt_next == tlc_pkg::POL_EOP_COUNT);

  // Jabber and unjab timers
  wire jab_hit = (jab_cnt_reg >= JAB_LIMIT - 1);
  wire unjab_hit = (unjab_cnt_reg >= UNJAB_LIMIT - 1);
  wire [31:0] jab_cnt_next = (s_reg.tx_en & ~jabbed_reg) ? jab_cnt_reg + 32'h1
                           : 32'h0;
  wire [31:0] unjab_cnt_next = (jabbed_reg & ~s_reg.tx_en) ? unjab_cnt_reg + 32'h1
                             : 32'h0;
  wire jabbed_next = jabbed_reg ? ~(unjab_hit & ~s_reg.tx_en)
                   : (s_reg.tx_en & jab_hit);

  // Transmit path and idle link pulses
  wire tx_ok = link_eff & ~jabbed_reg & ~lpbk_reg;
  wire tx_data_on = s_reg.tx_en & tx_ok;
  wire lp_wrap = (lp_cnt_reg >= LP_PERIOD - 1);
  wire [31:0] lp_cnt_next = (s_reg.tx_en | lp_wrap) ? 32'h0
                          : lp_cnt_reg + 32'h1;
  wire lp_on = ~s_reg.tx_en & (lp_cnt_reg >= LP_PERIOD - tlc_pkg::LP_WIDTH_CYC);
  wire drive = ~lpbk_reg & ~jabbed_reg & (tx_data_on | lp_on);
  wire line_bit = tx_data_on ? s_reg.txd : lp_on;

  // Receive path with loopback and polarity fix
  wire rx_act_eff = lpbk_reg ? s_reg.tx_en : (s_reg.rx_act & link_eff);
  wire rxd_eff = lpbk_reg ? s_reg.txd : (s_reg.rxd ^ bad_pol_reg);

  // Collision detection with seven-bit qualification
  wire col_cond = ~fdx & ~lpbk_reg & link_eff & s_reg.tx_en & s_reg.rx_act;
  wire [7:0] col_cnt_next = ~col_cond ? 8'h0
                          : (col_cnt_reg == 8'(tlc_pkg::COL_CYC)) ? col_cnt_reg
                          : col_cnt_reg + 8'h1;
  wire col_rep = col_cond & (col_cnt_reg == 8'(tlc_pkg::COL_CYC));
  wire col_start = col_cond & (col_cnt_reg == 8'(tlc_pkg::COL_CYC - 1));

  // Heartbeat: delay then signal quality error pulse
  wire [7:0] hb_last = 8'(tlc_pkg::HB_DELAY_CYC + tlc_pkg::SQE_CYC);
  wire [7:0] hb_cnt_next = (hb_cnt_reg != 8'h0) ? ((hb_cnt_reg == hb_last) ? 8'h0
                          : hb_cnt_reg + 8'h1)
                          : (tx_end & hb_en & ~fdx & ~lpbk_reg) ? 8'h1 : 8'h0;
  wire sqe_on = hb_cnt_reg > 8'(tlc_pkg::HB_DELAY_CYC);
  wire col_out = (col_rep | sqe_on) & ~fdx;

  // Interrupt events: link change, bad polarity, jabber, collision
  wire [3:0] events = {col_start, jabbed_next & ~jabbed_reg,
                       bad_pol_next & ~bad_pol_reg, link_ok_next ^ link_ok_reg};

  // Bus handshake state
  logic aw_full_reg;
  logic w_full_reg;
  logic [7:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic awready_reg;
  logic wready_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Write channel acceptance
  wire aw_take = s_axi_awvalid & awready_reg;
  wire w_take = s_axi_wvalid & wready_reg;
  wire do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
  wire aw_full_next = aw_take | (aw_full_reg & ~do_write);
  wire w_full_next = w_take | (w_full_reg & ~do_write);
  wire bvalid_next = do_write | (bvalid_reg & ~s_axi_bready);

  // Write address decode
  wire wr_ctrl = do_write & (waddr_reg == tlc_pkg::CTRL_OFF);
  wire wr_mask = do_write & (waddr_reg == tlc_pkg::INT_MASK_OFF);
  wire wr_lpbk = do_write & (waddr_reg == tlc_pkg::LOOPBACK_BYPASS_ERR_OFF);
  wire wr_cfg = do_write & (waddr_reg == tlc_pkg::TENMEG_CONFIG_OFF);
  wire wr_ro = do_write & ((waddr_reg == tlc_pkg::STAT_OFF)
                         | (waddr_reg == tlc_pkg::INT_STAT_OFF));
  wire wr_hit = wr_ctrl | wr_mask | wr_lpbk | wr_cfg | wr_ro;
  wire lo_en = wstrb_reg[0];
  wire [2:0] ctrl_next = (wr_ctrl & lo_en) ? wdata_reg[2:0] : ctrl_reg;
  wire [3:0] mask_next = (wr_mask & lo_en) ? wdata_reg[3:0] : int_mask_reg;
  wire lpbk_next = (wr_lpbk & wstrb_reg[1]) ? wdata_reg[tlc_pkg::LPBK_BIT]
                 : lpbk_reg;
  wire [1:0] cfg_next = (wr_cfg & lo_en)
                      ? {wdata_reg[tlc_pkg::CFG_CABLE_BIT], wdata_reg[tlc_pkg::CFG_LSS_BIT]}
                      : cfg_reg;

  // Read decode
  wire ar_take = s_axi_arvalid & arready_reg;
  wire rvalid_next = ar_take | (rvalid_reg & ~s_axi_rready);
  wire rd_ctrl = (s_axi_araddr == tlc_pkg::CTRL_OFF);
  wire rd_stat = (s_axi_araddr == tlc_pkg::STAT_OFF);
  wire rd_ist = (s_axi_araddr == tlc_pkg::INT_STAT_OFF);
  wire rd_mask = (s_axi_araddr == tlc_pkg::INT_MASK_OFF);
  wire rd_lpbk = (s_axi_araddr == tlc_pkg::LOOPBACK_BYPASS_ERR_OFF);
  wire rd_cfg = (s_axi_araddr == tlc_pkg::TENMEG_CONFIG_OFF);
  wire rd_hit = rd_ctrl | rd_stat | rd_ist | rd_mask | rd_lpbk | rd_cfg;
  wire [31:0] stat_word = {26'h0, rx_act_eff, tx_data_on, col_out,
                           jabbed_reg, bad_pol_reg, link_eff};
  wire [31:0] rd_word = rd_ctrl ? {29'h0, ctrl_reg}
                      : rd_stat ? stat_word
                      : rd_ist ? {28'h0, int_stat_reg}
                      : rd_mask ? {28'h0, int_mask_reg}
                      : rd_lpbk ? {20'h0, lpbk_reg, 11'h0}
                      : rd_cfg ? {28'h0, cfg_reg, 2'h0}
                      : 32'h0;

  // Sticky status, cleared by read, set wins
  wire rd_clr = ar_take & rd_ist;
  wire [3:0] int_stat_next = (rd_clr ? 4'h0 : int_stat_reg) | events;

  // Bus state update
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= tlc_pkg::RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= tlc_pkg::RESP_OKAY;
    end else begin
      aw_full_reg <= aw_full_next;
      w_full_reg <= w_full_next;
      awready_reg <= ~aw_full_next;
      wready_reg <= ~w_full_next;
      bvalid_reg <= bvalid_next;
      if (do_write) begin
        bresp_reg <= wr_hit ? tlc_pkg::RESP_OKAY : tlc_pkg::RESP_SLVERR;
      end
      arready_reg <= ~rvalid_next;
      rvalid_reg <= rvalid_next;
      if (ar_take) begin
        rdata_reg <= rd_word;
        rresp_reg <= rd_hit ? tlc_pkg::RESP_OKAY : tlc_pkg::RESP_SLVERR;
      end
    end
  end

  // Captured write address and data
  always_ff @(posedge aclk) begin
    if (aw_take) begin
      waddr_reg <= s_axi_awaddr;
    end
    if (w_take) begin
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end
  end

  // Software registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= tlc_pkg::CTRL_RST;
      int_mask_reg <= tlc_pkg::INT_MASK_RST;
      int_stat_reg <= 4'h0;
      lpbk_reg <= 1'b0;
      cfg_reg <= 2'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      int_mask_reg <= mask_next;
      int_stat_reg <= int_stat_next;
      lpbk_reg <= lpbk_next;
      cfg_reg <= cfg_next;
    end
  end

  // Link, polarity and jabber state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_ok_reg <= 1'b0;
      loss_cnt_reg <= 32'h0;
      bad_pol_reg <= 1'b0;
      lpi_cnt_reg <= 3'h0;
      eopi_cnt_reg <= 3'h0;
      jabbed_reg <= 1'b0;
      jab_cnt_reg <= 32'h0;
      unjab_cnt_reg <= 32'h0;
    end else begin
      link_ok_reg <= link_ok_next;
      loss_cnt_reg <= loss_cnt_next;
      bad_pol_reg <= bad_pol_next;
      lpi_cnt_reg <= lpi_cnt_next;
      eopi_cnt_reg <= eopi_cnt_next;
      jabbed_reg <= jabbed_next;
      jab_cnt_reg <= jab_cnt_next;
      unjab_cnt_reg <= unjab_cnt_next;
    end
  end

  // Pulse, collision and heartbeat timers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lp_cnt_reg <= 32'h0;
      col_cnt_reg <= 8'h0;
      hb_cnt_reg <= 8'h0;
    end else begin
      lp_cnt_reg <= lp_cnt_next;
      col_cnt_reg <= col_cnt_next;
      hb_cnt_reg <= hb_cnt_next;
    end
  end

  // Registered pin and indicator outputs
  logic [16:2] out_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_reg <= 15'h0;
    end else begin
      out_reg <= {col_out, rx_act_eff, rxd_eff,
                  cfg_reg[0], ~lpbk_reg,
                  line_bit, drive & ~use_stp, line_bit, drive & use_stp,
                  tx_data_on, rx_act_eff, link_eff, bad_pol_reg, col_out,
                  |(int_stat_next & mask_next)};
    end
  end

  // Output assignment
  assign mii_col = out_reg[16];
  assign mii_rx_dv = out_reg[15];
  assign mii_rxd = out_reg[14];
  assign low_squelch_select = out_reg[13];
  assign twisted_pair_rx_en = out_reg[12];
  assign unshielded_tx_pair_o = out_reg[11];
  assign unshielded_tx_pair_oe = out_reg[10];
  assign shielded_tx_pair_o = out_reg[9];
  assign shielded_tx_pair_oe = out_reg[8];
  assign led_tx = out_reg[7];
  assign led_rx = out_reg[6];
  assign link_indicator = out_reg[5];
  assign polarity_indicator = out_reg[4];
  assign led_col = out_reg[3];
  assign irq = out_reg[2];
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

endmodule : tlc_link_ctrl
`default_nettype wire

// ==== bench/tlc_link_monitor.sv ====
`default_nettype none
module tlc_link_monitor #(
  parameter int unsigned JAB_LIMIT = 100,
  parameter int unsigned UNJAB_LIMIT = 150
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Watched ports
  input wire logic mii_tx_en,
  input wire logic line_rx_act,
  input wire logic mii_col,
  input wire logic unshielded_tx_pair_o,
  input wire logic unshielded_tx_pair_oe,
  input wire logic shielded_tx_pair_oe,
  input wire logic polarity_indicator
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned tx_cnt;
  int unsigned low_cnt;
  logic jab_f;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Run lengths of transmit enable, jabber seen flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_cnt <= 0;
      low_cnt <= 0;
      jab_f <= 1'b0;
    end else begin
      tx_cnt <= mii_tx_en ? (tx_cnt < 100000 ? tx_cnt + 1 : tx_cnt) : 0;
      low_cnt <= mii_tx_en ? 0 : (low_cnt < 100000 ? low_cnt + 1 : low_cnt);
      jab_f <= (tx_cnt >= JAB_LIMIT + 8) || (jab_f && low_cnt + 4 < UNJAB_LIMIT);
    end
  end
  property p_pair_excl;
    !(unshielded_tx_pair_oe && shielded_tx_pair_oe);
  endproperty
  a_pair_excl: assert property (p_pair_excl) else $error("both pairs driven");
  property p_col_wait;
    $rose(mii_col) && mii_tx_en |-> $past(mii_tx_en && line_rx_act, 14);
  endproperty
  a_col_wait: assert property (p_col_wait) else $error("collision too early");
  property p_col_hold;
    $fell(mii_col) |-> !$past(mii_tx_en && line_rx_act);
  endproperty
  a_col_hold: assert property (p_col_hold) else $error("collision dropped");
  property p_hb_len;
    $rose(mii_col) && !mii_tx_en && !$past(mii_tx_en, 8) |->
      mii_col [*8] ##1 mii_col [*8] ##1 mii_col [*4] ##1 !mii_col;
  endproperty
  a_hb_len: assert property (p_hb_len) else $error("heartbeat width");
  property p_lp_width;
    $rose(unshielded_tx_pair_o) && !mii_tx_en && !$past(mii_tx_en, 6) |->
      ##1 unshielded_tx_pair_o ##1 !unshielded_tx_pair_o;
  endproperty
  a_lp_width: assert property (p_lp_width) else $error("link pulse width");
  property p_jab;
    tx_cnt >= JAB_LIMIT + 8 |-> !unshielded_tx_pair_oe && !shielded_tx_pair_oe;
  endproperty
  a_jab: assert property (p_jab) else $error("jabber not stopped");
  property p_unjab;
    jab_f && low_cnt + 4 < UNJAB_LIMIT |-> !unshielded_tx_pair_oe && !shielded_tx_pair_oe;
  endproperty
  a_unjab: assert property (p_unjab) else $error("early unjab");
  property p_pol_latch;
    polarity_indicator |=> polarity_indicator;
  endproperty
  a_pol_latch: assert property (p_pol_latch) else $error("polarity lost");
  // Main scenarios reached
  c_col: cover property ($rose(mii_col) && mii_tx_en);
  c_hb: cover property ($rose(mii_col) && !mii_tx_en);
  c_pol: cover property ($rose(polarity_indicator));
endmodule : tlc_link_monitor
`default_nettype wire

// ==== bench/tlc_remote_station.sv ====
`default_nettype none
module tlc_remote_station (
  // Clock
  input wire logic aclk,
  // Bench controls
  input wire logic pulses_on,
  input wire logic invert,
  input wire logic rx_on,
  input wire logic rx_bit,
  // Line toward the block
  output logic line_rx_act,
  output logic line_rxd,
  output logic line_lp,
  output logic line_lp_inv,
  output logic line_eop,
  output logic line_eop_inv
);
  timeunit 1ns;
  timeprecision 1ns;
  int tick;
  logic rx_q;
  logic pulse;
  // Pulse interval timer and receive history
  always_ff @(posedge aclk) begin
    tick <= (tick >= 149) ? 0 : tick + 1;
    rx_q <= rx_on;
  end
  // Link pulses, optionally with swapped wires
  assign pulse = pulses_on && (tick < 2);
  assign line_lp = pulse && !invert;
  assign line_lp_inv = pulse && invert;
  // Receive activity; idle line toggles rather than holding
  assign line_rx_act = rx_on;
  assign line_rxd = rx_on ? rx_bit : tick[0];
  assign line_eop = rx_q && !rx_on && !invert;
  assign line_eop_inv = rx_q && !rx_on && invert;
endmodule : tlc_remote_station
`default_nettype wire

// ==== bench/tlc_link_ctrl_tb.sv ====
`default_nettype none
module tlc_link_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic mii_tx_en, mii_txd, mii_col, mii_rx_dv, mii_rxd, line_rx_act, line_rxd;
  logic line_lp, line_lp_inv, line_eop, line_eop_inv, low_squelch_select;
  logic twisted_pair_rx_en, led_tx, led_rx, led_col, irq, link_indicator, polarity_indicator;
  logic unshielded_tx_pair_o, unshielded_tx_pair_oe, shielded_tx_pair_o, shielded_tx_pair_oe;
  logic pulses_on, invert, rx_on, rx_bit;
  int mismatches, compares, n;
  tlc_link_ctrl #(.LP_PERIOD(200), .JAB_LIMIT(100), .UNJAB_LIMIT(150), .LINK_LOSS(1000))
    i_dut (.*);
  tlc_remote_station i_far (.*);
  // Clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_resp
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  task automatic stall(input string what);
    mismatches++;
    $display("BAD %s expected done seen timeout", what);
    report_and_stop();
  endtask : stall
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && k < 100);
    if (k >= 100) stall("write");
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready) && k < 100);
    if (k >= 100) stall("read");
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  function automatic logic pick(input int sel);
    case (sel)
      0: return mii_col;
      1: return link_indicator;
      2: return polarity_indicator;
      3: return irq;
      4: return shielded_tx_pair_oe;
      default: return unshielded_tx_pair_oe;
    endcase
  endfunction : pick
  task automatic wait_for(input int sel, input int lim);
    n = 0;
    while (pick(sel) !== 1'b1 && n < lim) begin
      @(posedge aclk);
      n++;
    end
    if (n >= lim) stall("wait");
  endtask : wait_for
  // Adds the cycles a signal is seen high to n
  task automatic count(input int sel, input int c);
    repeat (c) begin
      @(posedge aclk);
      if (pick(sel) === 1'b1) n++;
    end
  endtask : count
  // Main sequence
  initial begin
    {mismatches, compares, n} = '0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {mii_tx_en, mii_txd, pulses_on, invert, rx_on, rx_bit} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(tlc_pkg::CTRL_OFF);
    chk("ctrl", {29'h0, tlc_pkg::CTRL_RST}, d);
    rd(tlc_pkg::INT_MASK_OFF);
    chk("mask", 32'h0, d);
    rd(8'h40);
    chk_resp("unmapped", tlc_pkg::RESP_SLVERR, r);
    chk("unmapped", 32'h0, d);
    wr(tlc_pkg::TENMEG_CONFIG_OFF, 32'hC);
    repeat (4) @(posedge aclk);
    chk("squelch", 32'h1, low_squelch_select);
    count(5, 300);
    chk("utp_oe", 32'h0, n);
    count(4, 300);
    chk("stp_oe", 32'h1, n > 0);
    wr(tlc_pkg::TENMEG_CONFIG_OFF, 32'h0);
    chk("link_off", 32'h0, link_indicator);
    wr(tlc_pkg::INT_MASK_OFF, 32'h1);
    pulses_on <= 1'b1;
    wait_for(1, 1200);
    wait_for(3, 20);
    rd(tlc_pkg::INT_STAT_OFF);
    chk("int_link", 32'h1, d[0]);
    repeat (3) @(posedge aclk);
    chk("irq_clr", 32'h0, irq);
    mii_tx_en <= 1'b1;
    rx_on <= 1'b1;
    wait_for(0, 60);
    chk("col_wait", 32'h1, n >= 14);
    n = 0;
    count(0, 30);
    chk("col_hold", 32'd30, n);
    chk("leds", 32'h7, {led_tx, led_rx, led_col});
    chk("irq_masked", 32'h0, irq);
    rx_on <= 1'b0;
    repeat (6) @(posedge aclk);
    chk("col_end", 32'h0, mii_col);
    mii_tx_en <= 1'b0;
    n = 0;
    count(0, 80);
    chk("heartbeat", tlc_pkg::SQE_CYC, n);
    rd(tlc_pkg::INT_STAT_OFF);
    chk("int_col", 32'h8, d & 32'h8);
    // Full duplex, then heartbeat off
    for (int i = 0; i < 2; i++) begin
      wr(tlc_pkg::CTRL_OFF, i ? 32'h0 : 32'h3);
      mii_tx_en <= 1'b1;
      rx_on <= (i == 0);
      n = 0;
      count(0, 40);
      mii_tx_en <= 1'b0;
      rx_on <= 1'b0;
      count(0, 60);
      chk("no_col", 32'h0, n);
    end
    wr(tlc_pkg::CTRL_OFF, 32'h2);
    mii_tx_en <= 1'b1;
    repeat (130) @(posedge aclk);
    chk("jab_oe", 32'h0, {unshielded_tx_pair_oe, shielded_tx_pair_oe});
    mii_tx_en <= 1'b0;
    repeat (90) @(posedge aclk);
    rd(tlc_pkg::STAT_OFF);
    chk("jabbed", 32'h4, d & 32'h4);
    repeat (80) @(posedge aclk);
    rd(tlc_pkg::STAT_OFF);
    chk("unjabbed", 32'h0, d & 32'h4);
    invert <= 1'b1;
    wait_for(2, 1600);
    invert <= 1'b0;
    wait_for(1, 400);
    rx_on <= 1'b1;
    rx_bit <= 1'b1;
    repeat (6) @(posedge aclk);
    chk("rxd_fix", 32'h0, mii_rxd);
    rx_on <= 1'b0;
    repeat (40) @(posedge aclk);
    chk("pol_latch", 32'h1, polarity_indicator);
    pulses_on <= 1'b0;
    repeat (1100) @(posedge aclk);
    chk("link_lost", 32'h0, link_indicator);
    wr(tlc_pkg::LOOPBACK_BYPASS_ERR_OFF, 32'h800);
    mii_tx_en <= 1'b1;
    mii_txd <= 1'b1;
    repeat (6) @(posedge aclk);
    chk("lb_dv", 32'h1, mii_rx_dv);
    chk("lb_rxd", 32'h1, mii_rxd);
    chk("lb_rx_en", 32'h0, twisted_pair_rx_en);
    chk("lb_oe", 32'h0, {unshielded_tx_pair_oe, shielded_tx_pair_oe});
    mii_txd <= 1'b0;
    repeat (6) @(posedge aclk);
    chk("lb_rxd0", 32'h0, mii_rxd);
    mii_tx_en <= 1'b0;
    wr(tlc_pkg::LOOPBACK_BYPASS_ERR_OFF, 32'h0);
    wr(tlc_pkg::CTRL_OFF, 32'h6);
    repeat (6) @(posedge aclk);
    chk("li_on", 32'h1, link_indicator);
    // Mid-run reset, then three packets with inverted end-of-packet
    aresetn <= 1'b0;
    invert <= 1'b1;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    chk("pol_rst", 32'h0, polarity_indicator);
    repeat (3) begin
      rx_on <= 1'b1;
      repeat (4) @(posedge aclk);
      rx_on <= 1'b0;
      repeat (4) @(posedge aclk);
    end
    wait_for(2, 20);
    report_and_stop();
  end
endmodule : tlc_link_ctrl_tb
bind tlc_link_ctrl tlc_link_monitor #(.JAB_LIMIT(JAB_LIMIT), .UNJAB_LIMIT(UNJAB_LIMIT))
  i_mon (.*);
`default_nettype wire
